// ---- verilog/dtec_pkg.sv ----
// Operation
// R1 - counter zero is 8-bit up-counter clocked by pin or clk/4
// R2 - counter one is 16-bit up-counter clocked by pin or clk/4
// R3 - control bit 3 picks pin edge: 0 rising, 1 falling
// R4 - control bit 4 enables counting when 1, stops when 0
// R5 - control bits 7:6 mode: 01 event, 10 timer, 11 pulse width
// R6 - control bits 0-2 and 5 always read zero
// R7 - 8-bit location: write sets preload, read gives live count
// R8 - low byte write fills buffer; high write loads both into preload
// R9 - high byte read returns live high and captures low into buffer
// R10 - event/timer modes count to all-ones then reload from preload
// R11 - overflow sets flag bit 5 or 6 of interrupt control
// R12 - event mode counts each selected pin edge
// R13 - timer mode counts at clk divided by four
// R14 - pulse mode: active edge starts clk/4 counting until level returns
// R15 - after one pulse measurement enable clears, result held
// R16 - event/timer modes never clear enable by hardware
// R17 - pulse mode overflow reloads and raises flag too
// R18 - overflow is a wake-up source from halt
// R19 - zero interrupt enable blocks that counter's service in all modes
// R20 - preload write while stopped also loads counter
// R21 - preload write while running changes preload only
// R22 - count clock blocked during a counter read
// R23 - count pins synchronised and edge detected before use
package dtec_pkg;
   localparam int  ADDR_W         = 5;  // word index bits, reaches interrupt control
   localparam int  DATA_W         = 32;
   localparam int  BYTE_W         = 8;
   // register word indices, byte address is four times these
   localparam logic [7:0] IDX_T0_COUNT = 8'h0d;
   localparam logic [7:0] IDX_T0_CTRL  = 8'h0e;
   localparam logic [7:0] IDX_T1_HIGH  = 8'h0f;
   localparam logic [7:0] IDX_T1_LOW   = 8'h10;
   localparam logic [7:0] IDX_T1_CTRL  = 8'h11;
   localparam logic [7:0] IDX_INTERRUPT_CONTROL     = 8'h12;
   // control fields
   localparam int  CTL_EDGE_BIT   = 3;
   localparam int  CTL_ON_BIT     = 4;
   localparam int  CTL_MODE_LO    = 6;
   localparam int  CTL_MODE_HI    = 7;
   localparam logic [7:0] CTL_WR_MASK = 8'hd8;
   localparam logic [7:0] CTL_RESET   = 8'h08;
   // interrupt control fields
   localparam int  INTERRUPT_CONTROL_EN0_BIT   = 2;
   localparam int  INTERRUPT_CONTROL_EN1_BIT   = 3;
   localparam int  INTERRUPT_CONTROL_F0_BIT    = 5;
   localparam int  INTERRUPT_CONTROL_F1_BIT    = 6;
   localparam logic [7:0] INTERRUPT_CONTROL_WR_MASK = 8'h7f;
   localparam int  PRESCALE       = 4;
   typedef enum logic [1:0] {
      dtec_mode_unused, dtec_mode_event, dtec_mode_timer, dtec_mode_pulse
   } dtec_mode_t;
endpackage : dtec_pkg

// ---- verilog/dtec_counter.sv ----
`timescale 1ns/1ps
module dtec_counter #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // configuration
   input  wire logic [1:0]       mode,
   input  wire logic             edge_polarity,
   input  wire logic             count_on,
   input  wire logic             tick,
   input  wire logic             hold,
   // preload write
   input  wire logic             preload_we,
   input  wire logic [WIDTH-1:0] preload_data,
   // raw count pin
   input  wire logic             count_pin,
   // status
   output logic [WIDTH-1:0]      count_value,
   output logic                  overflow,
   output logic                  measure_done
);
   import dtec_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] preload;
      logic [2:0]       sync;
      logic             lvl;
      logic             measuring;
      logic             done;
      logic             ovf;
      logic             fin;
   } dtec_cnt_state_t;

   dtec_cnt_state_t s_reg, s_next;
   logic pin_lvl, pin_prev, act_edge, inc;
   logic [WIDTH-1:0] all_ones;

   // filtered level moves only once stages two and three agree
   assign pin_prev = s_reg.lvl;
   assign pin_lvl  = (s_reg.sync[1] == s_reg.sync[2]) ? s_reg.sync[2] : s_reg.lvl;  // [R23]
   assign all_ones = '1;

   // next-state logic
   always_comb begin
      s_next     = s_reg;
      s_next.ovf = 1'b0;
      s_next.fin = 1'b0;
      s_next.sync = {s_reg.sync[1:0], count_pin};  // [R23]
      s_next.lvl  = pin_lvl;
      act_edge = edge_polarity ? (pin_prev & ~pin_lvl)
                               : (~pin_prev & pin_lvl);  // [R3] [R23]
      inc = 1'b0;
      if (count_on && !hold) begin  // [R4] [R22]
         unique case (dtec_mode_t'(mode))
            dtec_mode_event: inc = act_edge;  // [R12]
            dtec_mode_timer: inc = tick;  // [R13]
            dtec_mode_pulse: begin
               if (!s_reg.measuring && !s_reg.done && act_edge)
                  s_next.measuring = 1'b1;  // [R14]
               else if (s_reg.measuring && pin_lvl == edge_polarity) begin
                  s_next.measuring = 1'b0;  // [R14]
                  s_next.done      = 1'b1;  // [R15]
                  s_next.fin       = 1'b1;
               end
               inc = s_reg.measuring && tick && pin_lvl != edge_polarity;
            end
            dtec_mode_unused: inc = 1'b0;
         endcase
      end
      if (!count_on) begin
         s_next.measuring = 1'b0;
         s_next.done      = 1'b0;  // re-arm for next measurement
      end
      if (inc) begin
         if (s_reg.count == all_ones) begin
            s_next.count = s_reg.preload;  // [R10] [R17]
            s_next.ovf   = 1'b1;
         end else begin
            s_next.count = s_reg.count + 1'b1;  // [R1] [R2]
         end
      end
      if (preload_we) begin
         s_next.preload = preload_data;  // [R21]
         if (!count_on)
            s_next.count = preload_data;  // [R20]
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign count_value  = s_reg.count;
   assign overflow     = s_reg.ovf;
   assign measure_done = s_reg.fin;
endmodule : dtec_counter

// ---- verilog/dtec_top.sv ----
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dtec_top (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // avalon-mm slave
   input  wire logic [dtec_pkg::ADDR_W+1:0] address,
   input  wire logic                      read,
   input  wire logic                      write,
   input  wire logic [dtec_pkg::DATA_W-1:0] writedata,
   input  wire logic [3:0]                byteenable,
   output logic [dtec_pkg::DATA_W-1:0]    readdata,
   output logic                           waitrequest,
   // count pins
   input  wire logic                      counter_zero_pin,
   input  wire logic                      counter_one_pin,
   // system
   output logic                           counter_zero_irq,
   output logic                           counter_one_irq,
   output logic                           wake_up
);
   import dtec_pkg::*;

   typedef struct packed {
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [7:0]  interrupt_control;
      logic [7:0]  low_buf;
      logic [1:0]  div;
      logic        tick;
      logic        ack;
      logic [31:0] rdata;
      logic        wake;
   } dtec_top_state_t;

   dtec_top_state_t s_reg, s_next;
   logic [7:0]  cnt0;
   logic [15:0] cnt1;
   logic        ovf0, ovf1, fin0, fin1;
   logic        acc, wr_hit, rd_hit;
   logic [7:0]  idx, wbyte;
   logic        pl0_we, pl1_we, hold0, hold1;
   logic [15:0] pl1_data;

   // control readback masks unused bits
   function automatic logic [7:0] ctl_view(input logic [7:0] c);
      return c & CTL_WR_MASK;  // [R6]
   endfunction : ctl_view

   // bus decode, one wait cycle per access
   assign idx    = 8'(address[ADDR_W+1:2]);
   assign acc    = (read | write) & ~s_reg.ack;
   assign wr_hit = write & acc & byteenable[0];
   assign rd_hit = read & acc;
   assign wbyte  = writedata[7:0];
   assign waitrequest = ~s_reg.ack;
   assign pl0_we = wr_hit && idx == IDX_T0_COUNT;  // [R7]
   assign pl1_we = wr_hit && idx == IDX_T1_HIGH;  // [R8]
   assign pl1_data = {wbyte, s_reg.low_buf};  // [R8]
   // read stays high through its answer cycle, writes never block the count
   assign hold0  = read && idx == IDX_T0_COUNT;  // [R22]
   assign hold1  = read && (idx == IDX_T1_HIGH || idx == IDX_T1_LOW);  // [R22]

   // register file and prescaler
   always_comb begin
      s_next      = s_reg;
      s_next.ack  = acc;
      s_next.div  = s_reg.div + 2'd1;
      s_next.tick = s_reg.div == 2'(PRESCALE - 1);  // [R13]
      s_next.wake = ovf0 | ovf1;  // [R18]
      if (fin0)
         s_next.ctl0[CTL_ON_BIT] = 1'b0;  // [R15] [R16]
      if (fin1)
         s_next.ctl1[CTL_ON_BIT] = 1'b0;  // [R15] [R16]
      if (wr_hit) begin
         unique case (idx)
            IDX_T0_CTRL: s_next.ctl0 = wbyte & CTL_WR_MASK;  // [R4] [R5]
            IDX_T1_CTRL: s_next.ctl1 = wbyte & CTL_WR_MASK;  // [R4] [R5]
            IDX_T1_LOW:  s_next.low_buf = wbyte;  // [R8]
            IDX_INTERRUPT_CONTROL:    s_next.interrupt_control = wbyte & INTERRUPT_CONTROL_WR_MASK;
            default: ;
         endcase
      end
      // set beats clear on the same cycle
      if (ovf0)
         s_next.interrupt_control[INTERRUPT_CONTROL_F0_BIT] = 1'b1;  // [R11]
      if (ovf1)
         s_next.interrupt_control[INTERRUPT_CONTROL_F1_BIT] = 1'b1;  // [R11]
      if (rd_hit) begin
         s_next.rdata = '0;
         unique case (idx)
            IDX_T0_COUNT: s_next.rdata[7:0] = cnt0;  // [R7]
            IDX_T0_CTRL:  s_next.rdata[7:0] = ctl_view(s_reg.ctl0);  // [R6]
            IDX_T1_HIGH: begin
               s_next.rdata[7:0] = cnt1[15:8];  // [R9]
               s_next.low_buf    = cnt1[7:0];  // [R9]
            end
            IDX_T1_LOW:   s_next.rdata[7:0] = s_reg.low_buf;  // [R9]
            IDX_T1_CTRL:  s_next.rdata[7:0] = ctl_view(s_reg.ctl1);  // [R6]
            IDX_INTERRUPT_CONTROL:     s_next.rdata[7:0] = s_reg.interrupt_control;
            default:      s_next.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg      <= '0;
         s_reg.ctl0 <= CTL_RESET;
         s_reg.ctl1 <= CTL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // eight-bit counter
   dtec_counter #(.WIDTH(8)) u_cnt0 (
      .clk          (clk),
      .rst          (rst),
      .mode         (s_reg.ctl0[CTL_MODE_HI:CTL_MODE_LO]),
      .edge_polarity(s_reg.ctl0[CTL_EDGE_BIT]),
      .count_on     (s_reg.ctl0[CTL_ON_BIT]),
      .tick         (s_reg.tick),
      .hold         (hold0),
      .preload_we   (pl0_we),
      .preload_data (wbyte),
      .count_pin    (counter_zero_pin),
      .count_value  (cnt0),
      .overflow     (ovf0),
      .measure_done (fin0)
   );  // [R1]

   // sixteen-bit counter
   dtec_counter #(.WIDTH(16)) u_cnt1 (
      .clk          (clk),
      .rst          (rst),
      .mode         (s_reg.ctl1[CTL_MODE_HI:CTL_MODE_LO]),
      .edge_polarity(s_reg.ctl1[CTL_EDGE_BIT]),
      .count_on     (s_reg.ctl1[CTL_ON_BIT]),
      .tick         (s_reg.tick),
      .hold         (hold1),
      .preload_we   (pl1_we),
      .preload_data (pl1_data),
      .count_pin    (counter_one_pin),
      .count_value  (cnt1),
      .overflow     (ovf1),
      .measure_done (fin1)
   );  // [R2]

   // flag gated by its enable
   assign counter_zero_irq = s_reg.interrupt_control[INTERRUPT_CONTROL_F0_BIT] & s_reg.interrupt_control[INTERRUPT_CONTROL_EN0_BIT];  // [R19]
   assign counter_one_irq  = s_reg.interrupt_control[INTERRUPT_CONTROL_F1_BIT] & s_reg.interrupt_control[INTERRUPT_CONTROL_EN1_BIT];  // [R19]
   assign wake_up          = s_reg.wake;  // [R18]
   assign readdata         = s_reg.rdata;
endmodule : dtec_top

// ---- test/dtec_asserts.sv ----
`timescale 1ns/1ps
module dtec_asserts (
   // clock and reset
   input wire logic                        clk,
   input wire logic                        rst,
   // bus side
   input wire logic [dtec_pkg::ADDR_W+1:0] address,
   input wire logic                        read,
   input wire logic                        write,
   input wire logic [dtec_pkg::DATA_W-1:0] readdata,
   input wire logic                        waitrequest,
   // system
   input wire logic                        wake_up,
   input wire logic                        counter_zero_irq,
   input wire logic                        counter_one_irq
);
   import dtec_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // one wait state, answer lasts one cycle
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer after request");
   a_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   a_wait_cause: assert property (!waitrequest |-> $past(read || write))
      else $error("answer without request");
   a_wait_idle: assert property (waitrequest && !read && !write |=> waitrequest)
      else $error("answer while idle");
   // read data shape and hold
   a_data_upper: assert property (readdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   a_data_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("read data moved without read");
   a_ctrl_zero: assert property (read && !waitrequest && (8'(address[ADDR_W+1:2]) == IDX_T0_CTRL
      || 8'(address[ADDR_W+1:2]) == IDX_T1_CTRL) |-> (readdata[7:0] & 8'h27) == 8'h00)
      else $error("unused control bits set");
   // wake request is a single pulse
   a_wake_pulse: assert property (wake_up |=> !wake_up)
      else $error("wake pulse too long");
   // a raised request only drops through a software write
   a_irq0_hold: assert property (counter_zero_irq && !write |=> counter_zero_irq)
      else $error("counter zero request dropped without write");
   a_irq1_hold: assert property (counter_one_irq && !write |=> counter_one_irq)
      else $error("counter one request dropped without write");
endmodule : dtec_asserts

bind dtec_top dtec_asserts u_asserts (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest), .wake_up(wake_up),
   .counter_zero_irq(counter_zero_irq), .counter_one_irq(counter_one_irq));

// ---- test/dtec_pin_model.sv ----
`timescale 1ns/1ps
module dtec_pin_model (
   // clock
   input wire logic clk,
   // count pins
   output logic     pin0,
   output logic     pin1
);
   // pins idle low
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   // hold pin0 at a level for n cycles
   task automatic hold(input logic lvl, input int n);
      pin0 <= lvl;
      repeat (n) @(posedge clk);
   endtask : hold
   // n full pulses of width w
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         hold(1'b1, w);
         hold(1'b0, w);
      end
   endtask : pulses
endmodule : dtec_pin_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import dtec_pkg::*;
   logic                clk, rst, read, write, waitrequest, pin0, pin1, irq0, irq1, wake_up;
   logic [ADDR_W+1:0]   address;
   logic [DATA_W-1:0]   writedata, readdata;
   logic [3:0]          byteenable;
   logic [7:0]          q;
   int                  n_mismatch, total_checks, cycles, n;
   dtec_top DUT (.clk(clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .counter_zero_pin(pin0),
      .counter_one_pin(pin1), .counter_zero_irq(irq0), .counter_one_irq(irq1), .wake_up(wake_up));
   dtec_pin_model PM (.clk(clk), .pin0(pin0), .pin1(pin1));
   // clock
   always #2 clk = ~clk;
   // run length guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one transfer, held until waitrequest drops
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
      @(posedge clk);
      address    <= {idx[ADDR_W-1:0], 2'b00};
      writedata  <= {24'h00_0000, d};
      byteenable <= be;
      read       <= !wr;
      write      <= wr;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      q = readdata[7:0];
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus
   // count up to next wake pulse
   task automatic wait_wake();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!wake_up && n < 2000);
   endtask : wait_wake
   task automatic t_regs();
      bus(1'b0, IDX_T0_CTRL, 8'h00, 4'hf);
      check(q, 8'h08);
      bus(1'b0, 8'h04, 8'h00, 4'hf);
      check(q, 8'h00);
      bus(1'b1, IDX_T0_CTRL, 8'h27, 4'hf);
      bus(1'b0, IDX_T0_CTRL, 8'h00, 4'hf);
      check(q, 8'h00);
      bus(1'b1, IDX_T0_CTRL, 8'h18, 4'he);
      bus(1'b0, IDX_T0_CTRL, 8'h00, 4'hf);
      check(q, 8'h00);
      bus(1'b1, IDX_T0_COUNT, 8'h5a, 4'hf);
      bus(1'b0, IDX_T0_COUNT, 8'h00, 4'hf);
      check(q, 8'h5a);
   endtask : t_regs
   task automatic t_wide();
      bus(1'b1, IDX_T1_LOW, 8'h34, 4'hf);
      bus(1'b1, IDX_T1_HIGH, 8'h12, 4'hf);
      for (int i = 0; i < 2; i++) begin
         bus(1'b0, IDX_T1_HIGH, 8'h00, 4'hf);
         check(q, 8'h12);
         bus(1'b0, IDX_T1_LOW, 8'h00, 4'hf);
         check(q, 8'h34);
         bus(1'b1, IDX_T1_LOW, 8'h99, 4'hf);
      end
      // counter one in timer mode up to its overflow
      bus(1'b1, IDX_T1_LOW, 8'hf0, 4'hf);
      bus(1'b1, IDX_T1_HIGH, 8'hff, 4'hf);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h08, 4'hf);
      bus(1'b1, IDX_T1_CTRL, 8'h90, 4'hf);
      wait_wake();
      check(16'(n >= 50 && n <= 72), 16'h0001);
      check(irq1, 1'b1);
      bus(1'b0, IDX_INTERRUPT_CONTROL, 8'h00, 4'hf);
      check(q, 8'h48);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h40, 4'hf);
      check(irq1, 1'b0);
      bus(1'b1, IDX_T1_CTRL, 8'h80, 4'hf);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h00, 4'hf);
   endtask : t_wide
   task automatic t_timer();
      bus(1'b1, IDX_T0_COUNT, 8'hf0, 4'hf);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h04, 4'hf);
      bus(1'b1, IDX_T0_CTRL, 8'h90, 4'hf);
      bus(1'b1, IDX_T0_COUNT, 8'h80, 4'hf);
      wait_wake();
      check(16'(n >= 50 && n <= 72), 16'h0001);
      wait_wake();
      check(n[15:0], 16'h0200);
      bus(1'b0, IDX_T0_CTRL, 8'h00, 4'hf);
      check(q, 8'h90);
      check(irq0, 1'b1);
      bus(1'b0, IDX_INTERRUPT_CONTROL, 8'h00, 4'hf);
      check(q, 8'h24);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h20, 4'hf);
      check(irq0, 1'b0);
      bus(1'b1, IDX_T0_CTRL, 8'h80, 4'hf);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h00, 4'hf);
   endtask : t_timer
   task automatic t_event();
      logic [7:0] ctl [4] = '{8'h58, 8'h50, 8'h48, 8'h18};
      logic [7:0] exp [4] = '{8'h14, 8'h15, 8'h10, 8'h10};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, IDX_T0_CTRL, 8'h40, 4'hf);
         bus(1'b1, IDX_T0_COUNT, 8'h10, 4'hf);
         bus(1'b1, IDX_T0_CTRL, ctl[i], 4'hf);
         PM.pulses(4, 4);
         PM.hold(1'b1, 8);
         bus(1'b0, IDX_T0_COUNT, 8'h00, 4'hf);
         check(q, exp[i]);
         PM.hold(1'b0, 8);
      end
   endtask : t_event
   task automatic t_pulse();
      bus(1'b1, IDX_T0_CTRL, 8'h40, 4'hf);
      bus(1'b1, IDX_T0_COUNT, 8'hf8, 4'hf);
      bus(1'b1, IDX_T0_CTRL, 8'hd0, 4'hf);
      PM.hold(1'b1, 40);
      PM.hold(1'b0, 8);
      bus(1'b0, IDX_T0_COUNT, 8'h00, 4'hf);
      check(16'(q >= 8'hf9 && q <= 8'hfb), 16'h0001);
      n = q;
      bus(1'b0, IDX_INTERRUPT_CONTROL, 8'h00, 4'hf);
      check(q, 8'h20);
      check(irq0, 1'b0);
      bus(1'b0, IDX_T0_CTRL, 8'h00, 4'hf);
      check(q, 8'hc0);
      PM.pulses(1, 40);
      bus(1'b0, IDX_T0_COUNT, 8'h00, 4'hf);
      check(q, n[7:0]);
   endtask : t_pulse
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   // reset, then scenarios
   initial begin
      {clk, read, write, address, writedata, cycles, n_mismatch, total_checks} = '0;
      rst = 1'b1;
      byteenable = 4'hf;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_wide();
      t_timer();
      t_event();
      t_pulse();
      print_verdict();
   end
endmodule : testbench
